/* design/sat_defines.svh */
// Purpose: offsets, fields, reset values and timing counts of the acquisition time base
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef SAT_DEFINES_SVH
`define SAT_DEFINES_SVH
// ==========================================
// register byte offsets
`define SAT_CTRL_OFS      12'h000
`define SAT_STAT_OFS      12'h004
`define SAT_PRE_OFS       12'h008
`define SAT_POST_OFS      12'h00c
`define SAT_DIV_OFS       12'h010
`define SAT_INTERP_OFS    12'h014
`define SAT_IRQ_STAT_OFS  12'h018
`define SAT_IRQ_MASK_OFS  12'h01c
`define SAT_DAC_OFS       12'h020
`define SAT_RDPTR_OFS     12'h024
`define SAT_RDDATA_OFS    12'h028
// ==========================================
// control fields
`define SAT_CTRL_START    0
`define SAT_CTRL_SRC_LO   1
`define SAT_CTRL_CAL_LO   3
// ==========================================
// event bit positions
`define SAT_EV_ARM        0
`define SAT_EV_TRIG       1
`define SAT_EV_DONE       2
`define SAT_EV_INTERP     3
// ==========================================
// sizes and reset values
`define SAT_DEPTH         8000
`define SAT_PRE_RST       16'h0000
`define SAT_POST_RST      16'h0000
`define SAT_DIV_RST       16'h0000
// ==========================================
// timing: reference period in ns, one pclk is 50 ns
`define SAT_REF_PERIOD_NS 1
`define SAT_PCLK_NS       50
`endif

/* design/sat_pkg.sv */
// Purpose: types shared by the acquisition time base
// Assumes: nothing beyond the defines header
// Notes:   types only
package sat_pkg;
   // ==========================================
   // acquisition sequence states
   typedef enum logic [4:0] {
      SAT_IDLE = 5'b00001,
      SAT_PRE  = 5'b00010,
      SAT_ARM  = 5'b00100,
      SAT_POST = 5'b01000,
      SAT_DONE = 5'b10000
   } sat_state_t;
   // trigger source selection
   typedef enum logic [1:0] {
      SAT_SRC_CH1 = 2'h0,
      SAT_SRC_CH2 = 2'h1,
      SAT_SRC_LINK = 2'h2,
      SAT_SRC_EXT = 2'h3
   } sat_src_t;
   // rear calibration output selection
   typedef enum logic [1:0] {
      SAT_CAL_PROBE = 2'h0,
      SAT_CAL_TRIG  = 2'h1,
      SAT_CAL_SELF  = 2'h2,
      SAT_CAL_REF   = 2'h3
   } sat_cal_t;
   // one pair of converter samples
   typedef struct packed {
      logic [7:0] ch2;
      logic [7:0] ch1;
   } sat_sample_t;
   // static calibration dac update
   typedef struct packed {
      logic [3:0]  chan;
      logic [11:0] level;
   } sat_dac_t;
endpackage

/* design/sat_timebase.sv */
// Purpose: acquisition sequencing, ring sample memory and trigger time base
// Assumes: trigger and interpolator-done pins pass two flops; the reference runs as pclk in this model
// Notes:   apb slave, zero wait states, pslverr on unmapped offsets
// What this block does
// RULE1: ring holds 8000 samples per channel
// RULE2: ring loops, position tracked by clock count
// RULE3: two samples stored per memory clock
// RULE4: latch eight-bit results on sample clock
// RULE5: count pre-trigger samples, then assert arm
// RULE6: satisfied trigger starts post-trigger counter
// RULE7: countdown zero stops clocks, signals host
// RULE8: pulse from trigger to next sample clock
// RULE9: interpolator counter runs, stops, stores count
// RULE10: comparator true passes trigger to logic
// RULE11: four trigger sources selectable
// RULE12: calibration mux selects by mode
// RULE13: sample rate from programmable divider
// RULE14: drive sixteen-channel dac levels
// RULE15: host reads stored samples after capture
// RULE16: host programs counts before start
`include "sat_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sat_timebase
   import sat_pkg::*;
#(
   parameter int DEPTH = `SAT_DEPTH
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  adc_ch1,
   input  wire logic [7:0]  adc_ch2,
   input  wire logic        cmp_ch1,
   input  wire logic        cmp_ch2,
   input  wire logic        intermodule_trigger_link,
   input  wire logic        ext_trigger,
   input  wire logic        interp_done,
   input  wire logic        probe_comp,
   input  wire logic        self_cal,
   output logic             trigger_arm,
   output logic             sample_clk,
   output logic             interp_pulse,
   output logic             rear_calibration_mux,
   output logic [15:0]      static_calibration_level,
   output logic [3:0]       dac_chan,
   output logic             dac_load,
   output logic             acq_done,
   output logic             irq
);
   localparam int AW = $clog2(DEPTH);
   // ==========================================
   // pin synchronisers, first stage read only by second
   logic [3:0] trg_s1, trg_s2;
   logic       int_s1, int_s2;
   logic       int_s3;  // delayed copy for completion edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trg_s1 <= 4'h0;
         trg_s2 <= 4'h0;
         int_s1 <= 1'b0;
         int_s2 <= 1'b0;
         int_s3 <= 1'b0;
      end else begin
         trg_s1 <= {ext_trigger, intermodule_trigger_link, cmp_ch2, cmp_ch1};
         trg_s2 <= trg_s1;
         int_s1 <= interp_done;
         int_s2 <= int_s1;
         int_s3 <= int_s2;
      end
   end
   // ==========================================
   // registers
   logic [31:0] ctrl;          // start, source, cal mode
   logic [15:0] pre_cnt_cfg;   // pre-trigger samples
   logic [15:0] post_cnt_cfg;  // post-trigger samples
   logic [15:0] div_cfg;       // sample divider
   logic [3:0]  irq_stat;      // sticky events
   logic [3:0]  irq_mask;      // enables
   logic [AW-1:0] rd_ptr;      // host readout index
   logic [15:0] interp_count;  // stored interpolator count
   sat_state_t  state;
   // ==========================================
   // apb decode
   wire wr_en  = psel & penable & pwrite;
   wire rd_acc = psel & penable & ~pwrite;
   wire hit_ctrl   = paddr == `SAT_CTRL_OFS;
   wire hit_stat   = paddr == `SAT_STAT_OFS;
   wire hit_pre    = paddr == `SAT_PRE_OFS;
   wire hit_post   = paddr == `SAT_POST_OFS;
   wire hit_div    = paddr == `SAT_DIV_OFS;
   wire hit_interp = paddr == `SAT_INTERP_OFS;
   wire hit_istat  = paddr == `SAT_IRQ_STAT_OFS;
   wire hit_imask  = paddr == `SAT_IRQ_MASK_OFS;
   wire hit_dac    = paddr == `SAT_DAC_OFS;
   wire hit_rdptr  = paddr == `SAT_RDPTR_OFS;
   wire hit_rddata = paddr == `SAT_RDDATA_OFS;
   wire hit_any = hit_ctrl | hit_stat | hit_pre | hit_post | hit_div | hit_interp
                | hit_istat | hit_imask | hit_dac | hit_rdptr | hit_rddata;
   wire start_req = wr_en & hit_ctrl & pwdata[`SAT_CTRL_START];  // RULE16
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   // ==========================================
   // sample clock divider from reference
   logic [15:0] div_cnt;
   logic        running;
   wire         sample_tick = running & (div_cnt == div_cfg);  // RULE13
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 16'h0000;
      end else if (!running || sample_tick) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end
   // memory clock toggles per sample: stores on both edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_clk <= 1'b0;
      end else if (sample_tick) begin
         sample_clk <= ~sample_clk;  // RULE3
      end
   end
   // ==========================================
   // converter latch
   sat_sample_t adc_lat;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_lat <= '0;
      end else if (sample_tick) begin
         adc_lat <= '{ch2: adc_ch2, ch1: adc_ch1};  // RULE4
      end
   end
   // ==========================================
   // ring memory, written at a counted position
   sat_sample_t   ring [DEPTH];  // RULE1
   logic [AW-1:0] wr_pos;
   logic          lat_valid;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_pos    <= '0;
         lat_valid <= 1'b0;
      end else begin
         lat_valid <= sample_tick;
         if (lat_valid) begin
            // wrap, no direct addressing from outside
            wr_pos <= (wr_pos == AW'(DEPTH - 1)) ? '0 : wr_pos + 1'b1;  // RULE2
         end
      end
   end
   always_ff @(posedge pclk) begin
      if (lat_valid) begin
         ring[wr_pos] <= adc_lat;
      end
   end
   // ==========================================
   // trigger source and qualification
   wire [1:0] src_sel  = ctrl[`SAT_CTRL_SRC_LO +: 2];
   wire       trig_raw = trg_s2[src_sel];  // RULE11 RULE10
   logic      trig_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= trig_raw;
      end
   end
   wire trig_edge = trig_raw & ~trig_q;
   // ==========================================
   // sequence
   logic [15:0] seq_cnt;
   wire         trig_hit = (state == SAT_ARM) & trig_edge;
   wire         post_end = (state == SAT_POST) & sample_tick & (seq_cnt == 16'h0000);
   wire         pre_end  = (state == SAT_PRE) & sample_tick & (seq_cnt == 16'h0000);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= SAT_IDLE;
         seq_cnt <= 16'h0000;
      end else begin
         unique case (state)
            SAT_IDLE, SAT_DONE: begin
               if (start_req) begin
                  state   <= SAT_PRE;
                  seq_cnt <= pre_cnt_cfg;
               end
            end
            SAT_PRE: begin
               if (pre_end) begin
                  state <= SAT_ARM;  // RULE5
               end else if (sample_tick) begin
                  seq_cnt <= seq_cnt - 16'h0001;
               end
            end
            SAT_ARM: begin
               if (trig_hit) begin
                  state   <= SAT_POST;  // RULE6
                  seq_cnt <= post_cnt_cfg;
               end
            end
            SAT_POST: begin
               if (post_end) begin
                  state <= SAT_DONE;  // RULE7
               end else if (sample_tick) begin
                  seq_cnt <= seq_cnt - 16'h0001;
               end
            end
         endcase
      end
   end
   assign running     = (state == SAT_PRE) | (state == SAT_ARM) | (state == SAT_POST);
   assign trigger_arm = (state == SAT_ARM);
   assign acq_done    = (state == SAT_DONE);
   // ==========================================
   // interpolator pulse and counter
   logic interp_run;
   logic [15:0] interp_cnt;
   // completion is an edge: a done level left from the last run must not stop this one
   wire  int_rise = int_s2 & ~int_s3;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interp_pulse <= 1'b0;
         interp_run   <= 1'b0;
         interp_cnt   <= 16'h0000;
         interp_count <= 16'h0000;
      end else begin
         if (trig_hit) begin
            interp_pulse <= 1'b1;  // RULE8
         end else if (sample_tick) begin
            interp_pulse <= 1'b0;  // RULE8
         end
         if (trig_hit) begin
            interp_run <= 1'b1;
            interp_cnt <= 16'h0000;
         end else if (interp_run && int_rise) begin
            interp_run   <= 1'b0;  // RULE9
            interp_count <= interp_cnt;
         end else if (interp_run) begin
            interp_cnt <= interp_cnt + 16'h0001;  // RULE9
         end
      end
   end
   wire interp_end = interp_run & int_rise;
   // ==========================================
   // calibration mux; reference only at 1 ns period
   wire [1:0] cal_sel = ctrl[`SAT_CTRL_CAL_LO +: 2];
   wire       ref_ok  = (div_cfg == 16'h0000);
   assign rear_calibration_mux =
        (cal_sel == SAT_CAL_PROBE) ? probe_comp
      : (cal_sel == SAT_CAL_TRIG)  ? interp_pulse
      : (cal_sel == SAT_CAL_SELF)  ? self_cal
      : (ref_ok & sample_clk);  // RULE12
   // ==========================================
   // register writes, events set over clear
   wire [3:0] ev = {interp_end, post_end, trig_hit, pre_end};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl         <= 32'h0000_0000;
         pre_cnt_cfg  <= `SAT_PRE_RST;
         post_cnt_cfg <= `SAT_POST_RST;
         div_cfg      <= `SAT_DIV_RST;
         irq_mask     <= 4'h0;
         irq_stat     <= 4'h0;
         rd_ptr       <= '0;
      end else begin
         if (wr_en && hit_ctrl) ctrl <= {pwdata[31:1], 1'b0};
         if (wr_en && hit_pre) pre_cnt_cfg <= pwdata[15:0];
         if (wr_en && hit_post) post_cnt_cfg <= pwdata[15:0];
         if (wr_en && hit_div) div_cfg <= pwdata[15:0];
         if (wr_en && hit_imask) irq_mask <= pwdata[3:0];
         irq_stat <= (irq_stat & ~((wr_en & hit_istat) ? pwdata[3:0] : 4'h0)) | ev;
         if (wr_en && hit_rdptr) begin
            rd_ptr <= pwdata[AW-1:0];
         end else if (rd_acc && hit_rddata) begin
            // auto advance for slow readout
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;  // RULE15
         end
      end
   end
   assign irq = |(irq_stat & irq_mask);
   // ==========================================
   // dac update strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         static_calibration_level <= 16'h0000;
         dac_chan                 <= 4'h0;
         dac_load                 <= 1'b0;
      end else begin
         dac_load <= wr_en & hit_dac;  // RULE14
         if (wr_en && hit_dac) begin
            static_calibration_level <= pwdata[15:0];
            dac_chan                 <= pwdata[19:16];
         end
      end
   end
   // ==========================================
   // read mux; samples only readable when stopped
   sat_sample_t rd_word;
   assign rd_word = acq_done ? ring[rd_ptr] : '0;  // RULE15
   assign prdata =
        hit_ctrl   ? ctrl
      : hit_stat   ? {27'h0, state}
      : hit_pre    ? {16'h0, pre_cnt_cfg}
      : hit_post   ? {16'h0, post_cnt_cfg}
      : hit_div    ? {16'h0, div_cfg}
      : hit_interp ? {16'h0, interp_count}
      : hit_istat  ? {28'h0, irq_stat}
      : hit_imask  ? {28'h0, irq_mask}
      : hit_dac    ? {12'h0, dac_chan, static_calibration_level}
      : hit_rdptr  ? {{(32-AW){1'b0}}, rd_ptr}
      : hit_rddata ? {16'h0, rd_word}
      : 32'h0000_0000;
endmodule
`default_nettype wire

/* tb/sat_timebase_chk_properties.sv */
// Purpose: port-level properties of the acquisition time base
// Assumes: one clock domain, zero-wait apb slave
// Notes:   bound into every sat_timebase instance
`include "sat_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sat_timebase_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        trigger_arm,
   input wire logic        sample_clk,
   input wire logic        interp_pulse,
   input wire logic [15:0] static_calibration_level,
   input wire logic [3:0]  dac_chan,
   input wire logic        dac_load,
   input wire logic        acq_done
);
   // ==========================================
   // clocking, access decode and sequences
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc;   // access phase of any transfer
   assign acc = psel && penable;
   // dac write, then update pulse with the written word
   sequence s_dac_wr;
      acc && pwrite && paddr == `SAT_DAC_OFS;
   endsequence
   sequence s_dac_upd;
      dac_load && static_calibration_level == $past(pwdata[15:0])
         && dac_chan == $past(pwdata[19:16]);
   endsequence
   // ==========================================
   // properties
   chk_dac_update: assert property (s_dac_wr |=> s_dac_upd ##1 !dac_load)
      else $error("dac update wrong");
   chk_unmapped_err: assert property (acc && paddr > `SAT_RDDATA_OFS |-> pslverr)
      else $error("no error on unmapped offset");
   chk_mapped_ok: assert property (acc && paddr <= `SAT_RDDATA_OFS && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("error on mapped offset");
   chk_pready_high: assert property (pready)
      else $error("wait state inserted");
   chk_done_clk_stop: assert property (acq_done && $past(acq_done) |-> $stable(sample_clk))
      else $error("sample clock runs after done");
   chk_done_not_arm: assert property (acq_done |-> !trigger_arm && !interp_pulse)
      else $error("arm or pulse while done");
   chk_pulse_to_tick: assert property (interp_pulse && $past(interp_pulse)
      |-> $stable(sample_clk))
      else $error("pulse outlives sample tick");
   chk_pulse_from_arm: assert property ($rose(interp_pulse)
      |-> $past(trigger_arm) && !trigger_arm)
      else $error("pulse without armed trigger");
   chk_done_holds: assert property (acq_done && !(acc && pwrite && paddr == `SAT_CTRL_OFS)
      |=> acq_done)
      else $error("done dropped without restart");
endmodule
bind sat_timebase sat_timebase_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .trigger_arm(trigger_arm), .sample_clk(sample_clk),
   .interp_pulse(interp_pulse), .static_calibration_level(static_calibration_level),
   .dac_chan(dac_chan), .dac_load(dac_load), .acq_done(acq_done));
`default_nettype wire

/* tb/sat_far_model.sv */
// Purpose: trigger comparators and fine interpolator beside the time base
// Assumes: bench chooses source and fires a level
// Notes:   interpolator done stays high until the next pulse
`timescale 1ns/100ps
`default_nettype none
module sat_far_model #(
   parameter int STRETCH = 5
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       fire,
   input  wire logic [1:0] src,
   input  wire logic       interp_pulse,
   output logic            cmp_ch1,
   output logic            cmp_ch2,
   output logic            intermodule_trigger_link,
   output logic            ext_trigger,
   output logic            interp_done
);
   logic [7:0] cnt;   // stretch countdown
   // ==========================================
   // only the chosen source sees the condition met
   assign cmp_ch1 = fire && src == 2'h0;
   assign cmp_ch2 = fire && src == 2'h1;
   assign intermodule_trigger_link = fire && src == 2'h2;
   assign ext_trigger = fire && src == 2'h3;
   // stretch starts when the pulse ends; done marks completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         interp_done <= 1'b0;
      end else if (interp_pulse) begin   // new pulse restarts
         cnt <= 8'(STRETCH);
         interp_done <= 1'b0;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
         interp_done <= cnt == 8'h01;
      end
   end
endmodule
`default_nettype wire

/* tb/sat_timebase_tb.sv */
// Purpose: directed bench for the acquisition time base
// Assumes: apb tasks; far-side model supplies triggers
// Notes:   ring shortened to 16 entries to keep the run short
`include "sat_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module sat_timebase_tb;
   localparam int DEPTH = 16;    // shortened ring
   localparam int STRETCH = 5;   // interpolator stretch cycles
   // ==========================================
   // stimulus, observed wires, bookkeeping
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q;
   logic [7:0]  adc_ch1 = 8'h00, adc_ch2 = 8'h00;
   logic        probe_comp = 1'b0, self_cal = 1'b0, fire = 1'b0, e, last_clk = 1'b0;
   logic [1:0]  src = 2'h0;
   wire  [31:0] prdata;
   wire  [15:0] static_calibration_level;
   wire  [3:0]  dac_chan;
   wire         pready, pslverr, trigger_arm, sample_clk, interp_pulse, rear_calibration_mux;
   wire         dac_load, acq_done, irq, cmp_ch1, cmp_ch2, link_trig, ext_trigger, interp_done;
   int          mismatches = 0, num_checks = 0, ticks = 0, per = 0, cyc = 0, tcyc = 0, n, t0;
   always #25 pclk = ~pclk;   // 20 MHz
   sat_timebase #(.DEPTH(DEPTH)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_ch1(adc_ch1), .adc_ch2(adc_ch2),
      .cmp_ch1(cmp_ch1), .cmp_ch2(cmp_ch2), .intermodule_trigger_link(link_trig),
      .ext_trigger(ext_trigger), .interp_done(interp_done), .probe_comp(probe_comp),
      .self_cal(self_cal), .trigger_arm(trigger_arm), .sample_clk(sample_clk),
      .interp_pulse(interp_pulse), .rear_calibration_mux(rear_calibration_mux),
      .static_calibration_level(static_calibration_level), .dac_chan(dac_chan),
      .dac_load(dac_load), .acq_done(acq_done), .irq(irq));
   sat_far_model #(.STRETCH(STRETCH)) u_far (.pclk(pclk), .presetn(presetn), .fire(fire),
      .src(src), .interp_pulse(interp_pulse), .cmp_ch1(cmp_ch1), .cmp_ch2(cmp_ch2),
      .intermodule_trigger_link(link_trig), .ext_trigger(ext_trigger),
      .interp_done(interp_done));
   // ==========================================
   // tick monitor on the settled edge; counts and spacing of sample ticks
   always @(negedge pclk) begin
      cyc++;
      if (sample_clk !== last_clk) begin
         ticks++;
         per = cyc - tcyc;
         tcyc = cyc;
      end
      last_clk = sample_clk;
   end
   // one apb transfer; held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic re);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] rq);
      apb(1'b0, a, 32'h0, rq, e);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 3000 cycles
   initial begin
      #(20000 * 50);
      mismatches++;
      stop_test();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SAT_STAT_OFS, q); chk("stat_rst", 32'h1, q);
      for (int a = 8; a <= 28; a += 4) begin
         rd(a[11:0], q); chk("reg_rst", 32'h0, q);
      end
      apb(1'b0, 12'h100, 32'h0, q, e); chk("slverr", 32'h1, {31'h0, e});
      chk("unmapped", 32'h0, q);
      wr(`SAT_DAC_OFS, 32'h0005_0abc);
      @(negedge pclk); chk("level", 32'h0abc, {16'h0, static_calibration_level});
      chk("chan", 32'h5, {28'h0, dac_chan});
      probe_comp <= 1'b1;
      for (int m = 0; m < 4; m++) begin   // every calibration mode
         wr(`SAT_CTRL_OFS, 32'(m << 3));
         @(negedge pclk); chk("cal_mux", {31'h0, m == 0}, {31'h0, rear_calibration_mux});
      end
      for (int s = 0; s < 4; s++) begin   // one capture per trigger source
         adc_ch1 <= 8'h10 + 8'(s); adc_ch2 <= 8'hc0 + 8'(s); src <= 2'(s);
         // sixteen pre-trigger samples alone refill the whole shortened ring
         wr(`SAT_PRE_OFS, 32'hf); wr(`SAT_POST_OFS, 32'h9); wr(`SAT_DIV_OFS, 32'(s));
         wr(`SAT_IRQ_MASK_OFS, (s == 3) ? 32'h0 : 32'h4);   // last run masked
         wr(`SAT_CTRL_OFS, 32'((s << 1) | 1));
         ticks = 0;
         rd(`SAT_RDDATA_OFS, q); chk("early_read", 32'h0, q);
         for (n = 0; trigger_arm !== 1'b1 && n < 500; n++) @(posedge pclk);
         chk("pre_ticks", 32'h10, ticks); chk("period", 32'(s + 1), per);
         rd(`SAT_STAT_OFS, q); chk("armed", 32'h4, q);
         fire <= 1'b1;
         for (n = 0; interp_pulse !== 1'b1 && n < 50; n++) @(posedge pclk);
         t0 = ticks;
         for (n = 0; acq_done !== 1'b1 && n < 500; n++) @(posedge pclk);
         chk("post_ticks", 32'ha, ticks - t0);
         fire <= 1'b0;
         @(negedge pclk); chk("irq", {31'h0, s != 3}, {31'h0, irq});
         rd(`SAT_IRQ_STAT_OFS, q); chk("istat", 32'h4, q & 32'h4);
         wr(`SAT_IRQ_STAT_OFS, 32'hf);
         @(negedge pclk); chk("irq_clear", 32'h0, {31'h0, irq});
         rd(`SAT_INTERP_OFS, q); chk("interp", 32'h1, {31'h0, q >= STRETCH});
         rd(`SAT_STAT_OFS, q); chk("done", 32'h10, q);
         wr(`SAT_RDPTR_OFS, 32'h0);
         for (int i = 0; i <= DEPTH; i++) begin   // one past the end shows the wrap
            rd(`SAT_RDDATA_OFS, q); chk("ring", {16'h0, adc_ch2, adc_ch1}, q);
         end
      end
      stop_test();
   end
endmodule
`default_nettype wire
